// ---- common/tas_pkg.sv ----
`default_nettype none
package tas_pkg;

  // register pointer codes
  localparam logic [1:0] TAS_PTR_TEMP  = 2'h0;
  localparam logic [1:0] TAS_PTR_CONF  = 2'h1;
  localparam logic [1:0] TAS_PTR_THYST = 2'h2;
  localparam logic [1:0] TAS_PTR_TOS   = 2'h3;
  localparam logic [1:0] TAS_PTR_RST   = TAS_PTR_TEMP;

  // power-up values: 80 C and 75 C at 0.5 C per step
  localparam logic [7:0] TAS_CONF_RST  = 8'h00;
  localparam logic [8:0] TAS_TOS_RST   = 9'h0a0;
  localparam logic [8:0] TAS_THYST_RST = 9'h096;

  // target address: upper four bits fixed, lower three from pins (value arbitrary)
  localparam logic [3:0] TAS_ADDR_BASE = 4'h9;

  // byte framing: eight data bits, then the acknowledge slot
  localparam logic [3:0] TAS_BITS_PER_BYTE = 4'h8;

  // temperature field positions
  localparam int TAS_TEMP_W  = 11;
  localparam int TAS_LIMIT_W = 9;

  // bus fault time-out, least value of the allowed window
  localparam int TAS_CLK_HZ       = 10_000_000;
  localparam int TAS_TIMEOUT_MS   = 75;
  localparam int TAS_TIMEOUT_CYC  = (TAS_CLK_HZ / 1000) * TAS_TIMEOUT_MS;
  localparam int TAS_TIMEOUT_W    = 20;

  // fault queue counts per code
  localparam logic [2:0] TAS_FQ_CNT0 = 3'h1;
  localparam logic [2:0] TAS_FQ_CNT1 = 3'h2;
  localparam logic [2:0] TAS_FQ_CNT2 = 3'h4;
  localparam logic [2:0] TAS_FQ_CNT3 = 3'h6;

  typedef struct packed {
    logic [2:0] spare;
    logic [1:0] queue;
    logic       polarity;
    logic       mode;
    logic       shutdown;
  } tas_cfg_t;

  typedef struct packed {
    logic [8:0] tos;
    logic [8:0] thyst;
  } tas_limits_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_DATA, ST_WR_ACK, ST_RD_DATA, ST_RD_ACK
  } tas_state_t;

  function automatic logic [2:0] tas_fq_need(input logic [1:0] code);
    case (code)
      2'h0:    tas_fq_need = TAS_FQ_CNT0;
      2'h1:    tas_fq_need = TAS_FQ_CNT1;
      2'h2:    tas_fq_need = TAS_FQ_CNT2;
      default: tas_fq_need = TAS_FQ_CNT3;
    endcase
  endfunction

endpackage
`default_nettype wire

// ---- rtl/tas_alert_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module tas_alert_engine
  import tas_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        conv_done_in,
  input  wire logic [8:0]  temp9_in,
  input  wire tas_limits_t limits_in,
  input  wire tas_cfg_t    cfg_in,
  input  wire logic        read_clear_in,
  output logic             alert_active_out
);

  logic       hot;
  logic       latch;
  logic       sd_q;
  logic [2:0] run;
  logic [2:0] need;
  logic       conv_ok;
  logic       trip;
  logic       fire;
  logic       sd_rise;

  assign need    = tas_fq_need(cfg_in.queue);
  // converter is halted in shutdown, so late results are ignored
  assign conv_ok = conv_done_in & ~cfg_in.shutdown; // R13
  // hot waits for the low limit, cold waits for the high limit
  assign trip    = hot ? ($signed(temp9_in) < $signed(limits_in.thyst))
                       : ($signed(temp9_in) > $signed(limits_in.tos)); // R5 R23
  assign fire    = conv_ok & trip & ((run + 3'h1) >= need); // R9 R10
  assign sd_rise = cfg_in.shutdown & ~sd_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run <= 3'h0;
    end else if (conv_ok) begin
      if (!trip || fire) begin
        run <= 3'h0; // R24
      end else begin
        run <= run + 3'h1; // R9
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hot <= 1'b0;
    end else if (fire) begin
      hot <= ~hot; // R5 R7
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sd_q <= 1'b0;
    end else begin
      sd_q <= cfg_in.shutdown;
    end
  end

  // an event in the same cycle as a read beats the clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch <= 1'b0;
    end else if (fire && cfg_in.mode) begin
      latch <= 1'b1; // R7
    end else if (read_clear_in || sd_rise || !cfg_in.mode) begin
      latch <= 1'b0; // R7 R14
    end
  end

  assign alert_active_out = cfg_in.mode ? latch : hot; // R3 R6

  a_comp_assert: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R5
    conv_ok && !hot && trip && need == 3'h1 && !cfg_in.mode && !$changed(cfg_in)
      |=> alert_active_out)
    else $error("comparator alert not raised on trip");
  a_run_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R24
    conv_ok && !trip |=> run == 3'h0)
    else $error("trip run not cleared");
  a_queue_wait: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R10
    conv_ok && trip && run == 3'h0 && need > 3'h1 |=> hot == $past(hot))
    else $error("alert moved before queue filled");
  a_int_read: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R7
    cfg_in.mode && read_clear_in && !fire |=> !latch)
    else $error("read did not clear latched alert");
  a_sd_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R14
    cfg_in.mode && sd_rise && !fire |=> !latch)
    else $error("shutdown did not clear latched alert");
  a_sd_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R6
    !cfg_in.mode && !$past(cfg_in.mode) && cfg_in.shutdown && $past(cfg_in.shutdown)
      |-> $stable(alert_active_out))
    else $error("comparator alert moved in shutdown");

endmodule
`default_nettype wire

// ---- rtl/tas_sensor_port.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] Polarity bit B2: 1 makes the alert pin active high, 0 active low.
// [R2] Polarity bit resets to 0, so the alert starts active low.
// [R3] Mode bit B1: 1 selects latched interrupt, 0 selects comparator.
// [R4] Mode bit resets to 0, comparator behaviour by default.
// [R5] Comparator: assert above overtemp limit, release below hysteresis limit.
// [R6] Comparator: reads and entering shutdown leave the alert unchanged.
// [R7] Interrupt: assert on either crossing, hold until any register read.
// [R8] Host keeps overtemp limit above hysteresis limit, else alert undefined.
// [R9] Trips judged at conversion end; alert after enough consecutive trips.
// [R10] Queue bits B4:B3 codes 0..3 need 1, 2, 4, 6 trips.
// [R11] Queue code resets to 0, a single trip suffices.
// [R12] Bit B0 set selects shutdown, cleared returns to normal.
// [R13] Shutdown halts conversions; bus reads and writes still work.
// [R14] Shutdown keeps comparator alert, clears an asserted interrupt alert.
// [R15] Reset loads 80 C, 75 C, normal mode, pointer on temperature.
// [R16] Each byte is nine host clocks: eight data plus acknowledge.
// [R17] Device pulls SDA low in its acknowledge slot, host released.
// [R18] Host acknowledges after first read byte to get the second.
// [R19] Read ends with both sides released: not-acknowledge, then stop.
// [R20] Host reads after pointer write via repeated start and read address.
// [R21] Temperature readable as one or two bytes; SDA never left low.
// [R22] SDA low beyond the fault time-out abandons transfer, releases bus.
// [R23] Compare uses the nine top bits of the temperature reading.
// [R24] A conversion without trip clears the consecutive trip count.
module tas_sensor_port
  import tas_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TAS_TIMEOUT_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic [2:0]  addr_sel_in,
  input  wire logic [10:0] temp_data_in,
  input  wire logic        conv_done_in,
  output logic             conv_enable_out,
  output logic             over_temp_alert_out,
  output logic             over_temp_alert_oe_out
);

  localparam logic [TAS_TIMEOUT_W-1:0] TO_LIM = TIMEOUT_CYCLES[TAS_TIMEOUT_W-1:0];

  // pin synchronisers: _m stage feeds only _s stage
  logic       scl_m, scl_s, scl_d;
  logic       sda_m, sda_s, sda_d;
  logic [2:0] asel_m, asel_s;

  tas_state_t  state;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [1:0]  byte_idx;
  logic        rw;
  logic        sda_oe;
  logic        ack_seen;
  logic [1:0]  ptr;
  tas_cfg_t    conf;
  tas_limits_t limits;
  logic [7:0]  msb_hold;
  logic [TAS_TIMEOUT_W-1:0] to_cnt;
  logic        alert_active;
  logic        alert_oe;

  logic scl_rise, scl_fall;
  logic start_cond, stop_cond;
  logic timeout_hit;
  logic addr_hit;
  logic byte_end;
  logic wr_byte_done;
  logic read_clear;
  logic [7:0] first_tx;
  logic [7:0] next_tx;

  // byte of a register for the msb (0) or lsb (1) position
  function automatic logic [7:0] rd_byte(input logic [1:0] p, input logic lsb,
                                         input logic [10:0] t, input tas_cfg_t c,
                                         input tas_limits_t l);
    logic [15:0] w;
    w = 16'h0000;
    case (p)
      TAS_PTR_TEMP:  w = {t, 5'h00};
      TAS_PTR_CONF:  w = {c, c};
      TAS_PTR_THYST: w = {l.thyst, 7'h00};
      TAS_PTR_TOS:   w = {l.tos, 7'h00};
      default:       w = 16'h0000;
    endcase
    rd_byte = lsb ? w[7:0] : w[15:8];
  endfunction

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_m  <= 1'b1;
      scl_s  <= 1'b1;
      scl_d  <= 1'b1;
      sda_m  <= 1'b1;
      sda_s  <= 1'b1;
      sda_d  <= 1'b1;
      asel_m <= 3'h0;
      asel_s <= 3'h0;
    end else begin
      scl_m  <= scl_in;
      scl_s  <= scl_m;
      scl_d  <= scl_s;
      sda_m  <= sda_in;
      sda_s  <= sda_m;
      sda_d  <= sda_s;
      asel_m <= addr_sel_in;
      asel_s <= asel_m;
    end
  end

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  assign addr_hit   = (shreg[7:1] == {TAS_ADDR_BASE, asel_s});
  // eighth data bit has been clocked, ninth pulse begins
  assign byte_end   = scl_fall && (bitcnt == TAS_BITS_PER_BYTE); // R16
  assign first_tx   = rd_byte(ptr, 1'b0, temp_data_in, conf, limits);
  assign next_tx    = rd_byte(ptr, ~byte_idx[0], temp_data_in, conf, limits);

  // bus fault time-out: a host that stalls with SDA low cannot hang us
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      to_cnt <= '0;
    end else if (sda_s) begin
      to_cnt <= '0;
    end else if (to_cnt != TO_LIM) begin
      to_cnt <= to_cnt + 1'b1;
    end
  end

  assign timeout_hit = ~sda_s && (to_cnt == TO_LIM - 1'b1); // R22

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state    <= ST_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      byte_idx <= 2'h0;
      rw       <= 1'b0;
      sda_oe   <= 1'b0;
      ack_seen <= 1'b0;
    end else if (timeout_hit || stop_cond) begin
      state  <= ST_IDLE; // R22
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state  <= ST_ADDR; // R20
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_ADDR, ST_WR_DATA: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_end) begin
            if (state == ST_WR_DATA) begin
              sda_oe <= 1'b1; // R17
              state  <= ST_WR_ACK;
            end else if (addr_hit) begin
              sda_oe <= 1'b1; // R17
              rw     <= shreg[0];
              state  <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            byte_idx <= 2'h0;
            bitcnt   <= 4'h0;
            if (rw) begin
              shreg  <= first_tx;
              sda_oe <= ~first_tx[7];
              state  <= ST_RD_DATA;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_WR_DATA;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            if (byte_idx != 2'h3) begin
              byte_idx <= byte_idx + 2'h1;
            end
            state <= ST_WR_DATA;
          end
        end
        ST_RD_DATA: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_end) begin
            sda_oe <= 1'b0; // R17
            state  <= ST_RD_ACK;
          end else if (scl_fall) begin
            shreg  <= {shreg[6:0], 1'b0};
            sda_oe <= ~shreg[6];
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            ack_seen <= ~sda_s; // R18
          end else if (scl_fall) begin
            bitcnt <= 4'h0;
            if (ack_seen) begin
              byte_idx <= byte_idx + 2'h1;
              shreg    <= next_tx;
              sda_oe   <= ~next_tx[7];
              state    <= ST_RD_DATA;
            end else begin
              // not acknowledged: stay off the line until the stop
              sda_oe <= 1'b0; // R19 R21
              state  <= ST_IDLE;
            end
          end
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  assign wr_byte_done = (state == ST_WR_DATA) && byte_end && !timeout_hit;
  assign read_clear   = (state == ST_ADDR) && byte_end && addr_hit && shreg[0]
                        && !timeout_hit; // R7

  // pointer and limit registers; partial limit writes are dropped
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr      <= TAS_PTR_RST; // R15
      msb_hold <= 8'h00;
      limits   <= '{tos: TAS_TOS_RST, thyst: TAS_THYST_RST}; // R15
    end else if (wr_byte_done) begin
      case (byte_idx)
        2'h0: begin
          ptr <= shreg[1:0];
        end
        2'h1: begin
          msb_hold <= shreg;
        end
        2'h2: begin
          if (ptr == TAS_PTR_TOS) begin
            limits.tos <= {msb_hold, shreg[7]};
          end else if (ptr == TAS_PTR_THYST) begin
            limits.thyst <= {msb_hold, shreg[7]};
          end
        end
        default: begin
          msb_hold <= msb_hold;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conf <= tas_cfg_t'(TAS_CONF_RST); // R2 R4 R11 R15
    end else if (wr_byte_done && byte_idx == 2'h1 && ptr == TAS_PTR_CONF) begin
      conf <= tas_cfg_t'(shreg); // R12
    end
  end

  tas_alert_engine u_alert (
    .clk_in           (clk_in),
    .rst_b_in         (rst_b_in),
    .conv_done_in     (conv_done_in),
    .temp9_in         (temp_data_in[TAS_TEMP_W-1:TAS_TEMP_W-TAS_LIMIT_W]), // R23
    .limits_in        (limits),
    .cfg_in           (conf),
    .read_clear_in    (read_clear),
    .alert_active_out (alert_active)
  );

  // open drain: pulled low when the pin level should be low
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= conf.polarity ? ~alert_active : alert_active; // R1
    end
  end

  assign sda_out                = 1'b0;
  assign sda_oe_out             = sda_oe;
  assign conv_enable_out        = ~conf.shutdown; // R12 R13
  assign over_temp_alert_out    = 1'b0;
  assign over_temp_alert_oe_out = alert_oe;

  a_pol_pin: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R1
    $past(conf.polarity) == conf.polarity && $past(alert_active) == alert_active
      |-> alert_oe == (conf.polarity ^ alert_active))
    else $error("alert pin level wrong for polarity");
  a_ack_drive: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R17
    state == ST_WR_ACK || state == ST_ADDR_ACK |-> sda_oe_out)
    else $error("acknowledge slot not driven low");
  a_nack_free: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R21
    state == ST_RD_ACK && scl_fall && !ack_seen && !start_cond
      |=> !sda_oe_out [*2])
    else $error("sda held after not-acknowledge");
  a_to_release: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R22
    timeout_hit |=> state == ST_IDLE && !sda_oe_out)
    else $error("time-out did not release bus");
  a_rd_release: assert property (@(posedge clk_in) disable iff (!rst_b_in) // R19
    state == ST_RD_DATA && byte_end && !timeout_hit && !stop_cond |=> state == ST_RD_ACK
      && !sda_oe_out)
    else $error("read acknowledge slot not released");

endmodule
`default_nettype wire

// ---- testbench/tas_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tas_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // bus clock stands high between frames; data line has a pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // a quarter bit: device answers 3 edges after scl falls, so 8 leaves margin
  task automatic half();
    repeat (8) @(posedge clk_in);
  endtask

  task automatic start();
    sda_low_out <= 1'b0;
    half();
    scl_out <= 1'b1;
    half();
    sda_low_out <= 1'b1;
    half();
    scl_out <= 1'b0;
    half();
  endtask

  task automatic stop();
    sda_low_out <= 1'b1;
    half();
    scl_out <= 1'b1;
    half();
    sda_low_out <= 1'b0;
    half();
  endtask

  // data changes only while scl is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_out <= ~b;
    half();
    scl_out <= 1'b1;
    half();
    r = sda_in;
    half();
    scl_out <= 1'b0;
    half();
  endtask

  // eight data clocks then the acknowledge clock; ack_b 1 releases the line
  task automatic byte_io(input logic [7:0] d, input logic ack_b,
                         output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_b, ack);
  endtask
endmodule
`default_nettype wire

// ---- testbench/tas_sensor_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tas_sensor_port_tb
  import tas_pkg::*;
;
  localparam int          TMO  = 1000;
  localparam logic [10:0] HOT  = 11'h288;
  localparam logic [10:0] COLD = 11'h240;
  localparam logic [10:0] MID  = 11'h270;
  logic        clk_in;
  logic        rst_b_in;
  logic [2:0]  addr_sel_in;
  logic [10:0] temp_data_in;
  logic        conv_done_in;
  logic        scl;
  logic        host_low;
  logic        sda_out;
  logic        sda_oe_out;
  logic        conv_enable_out;
  logic        alert_out;
  logic        alert_oe;
  wire logic   sda_wire;
  int          fail_count;
  int          tests_run;
  int          need;
  logic [7:0]  q8;
  logic        a;

  // open-drain data line with pull-up
  assign sda_wire = ~host_low & (sda_oe_out ? sda_out : 1'b1);

  tas_sensor_port #(.TIMEOUT_CYCLES(TMO)) tas_sensor_port_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_sel_in(addr_sel_in),
    .temp_data_in(temp_data_in), .conv_done_in(conv_done_in),
    .conv_enable_out(conv_enable_out), .over_temp_alert_out(alert_out),
    .over_temp_alert_oe_out(alert_oe));

  tas_host_model tas_host_model_inst (
    .clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(host_low));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // pin level seen through the pull-up
  task automatic pin(input logic pol, input logic act);
    check({15'h0, alert_oe ? alert_out : 1'b1}, {15'h0, ~(act ^ pol)});
  endtask

  task automatic xb(input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    tas_host_model_inst.byte_io(d, 1'b1, q, k);
    check({15'h0, k}, 16'h0);
  endtask

  task automatic wr(input logic [1:0] p, input logic [15:0] v);
    tas_host_model_inst.start();
    xb({TAS_ADDR_BASE, addr_sel_in, 1'b0});
    xb({6'h0, p});
    xb(v[15:8]);
    // second data byte completes a limit write; ignored for the config byte
    xb(v[7:0]);
    tas_host_model_inst.stop();
  endtask

  task automatic rd(input logic [1:0] p, input logic setp, input int n,
                    input logic [15:0] exp);
    logic [15:0] q = '0;
    logic        k;
    if (setp) begin
      tas_host_model_inst.start();
      xb({TAS_ADDR_BASE, addr_sel_in, 1'b0});
      xb({6'h0, p});
    end
    tas_host_model_inst.start();
    xb({TAS_ADDR_BASE, addr_sel_in, 1'b1});
    tas_host_model_inst.byte_io(8'hff, n == 1, q[15:8], k);
    if (n > 1) tas_host_model_inst.byte_io(8'hff, 1'b1, q[7:0], k);
    check({15'h0, sda_oe_out}, 16'h0);
    tas_host_model_inst.stop();
    check(q, exp);
  endtask

  task automatic conv(input logic [10:0] t, input int k);
    repeat (k) begin
      temp_data_in <= t;
      conv_done_in <= 1'b1;
      @(posedge clk_in);
      conv_done_in <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial begin
    repeat (90000) @(posedge clk_in);
    fail_count++;
    final_report();
  end

  initial begin
    fail_count = 0;
    tests_run = 0;
    rst_b_in = 1'b0;
    addr_sel_in = 3'h5;
    temp_data_in = MID;
    conv_done_in = 1'b0;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    conv(MID, 1);
    pin(1'b0, 1'b0);
    check({15'h0, conv_enable_out}, 16'h1);
    rd(TAS_PTR_TEMP, 1'b0, 2, 16'h4e00);
    rd(TAS_PTR_CONF, 1'b1, 2, 16'h0000);
    rd(TAS_PTR_TOS, 1'b1, 2, 16'h5000);
    rd(TAS_PTR_THYST, 1'b1, 2, 16'h4b00);
    rd(TAS_PTR_TEMP, 1'b1, 1, 16'h4e00);
    // hysteresis limit stays below the overtemp limit; temperatures keep their sides
    wr(TAS_PTR_THYST, 16'h4b80);
    rd(TAS_PTR_THYST, 1'b1, 2, 16'h4b80);
    // equal to the limit in nine bits, above it in eleven
    conv(11'h283, 1);
    pin(1'b0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      need = (c == 0) ? 1 : c * 2;
      wr(TAS_PTR_CONF, {3'h0, c[1:0], 11'h0});
      conv(HOT, need - 1);
      conv(COLD, 1);
      conv(HOT, need - 1);
      pin(1'b0, 1'b0);
      conv(HOT, 1);
      pin(1'b0, 1'b1);
      rd(TAS_PTR_CONF, 1'b1, 2, {2{3'h0, c[1:0], 3'h0}});
      pin(1'b0, 1'b1);
      conv(MID, need);
      conv(COLD, need - 1);
      pin(1'b0, 1'b1);
      conv(COLD, 1);
      pin(1'b0, 1'b0);
    end
    wr(TAS_PTR_CONF, 16'h0000);
    conv(HOT, 1);
    wr(TAS_PTR_CONF, 16'h0100);
    pin(1'b0, 1'b1);
    check({15'h0, conv_enable_out}, 16'h0);
    conv(COLD, 1);
    pin(1'b0, 1'b1);
    rd(TAS_PTR_CONF, 1'b1, 1, 16'h0100);
    wr(TAS_PTR_CONF, 16'h0000);
    check({15'h0, conv_enable_out}, 16'h1);
    conv(COLD, 1);
    pin(1'b0, 1'b0);
    wr(TAS_PTR_CONF, 16'h0400);
    pin(1'b1, 1'b0);
    conv(HOT, 1);
    pin(1'b1, 1'b1);
    conv(COLD, 1);
    pin(1'b1, 1'b0);
    wr(TAS_PTR_CONF, 16'h0200);
    conv(HOT, 1);
    pin(1'b0, 1'b1);
    rd(TAS_PTR_TEMP, 1'b1, 2, 16'h5100);
    pin(1'b0, 1'b0);
    conv(HOT, 1);
    pin(1'b0, 1'b0);
    conv(COLD, 1);
    pin(1'b0, 1'b1);
    wr(TAS_PTR_CONF, 16'h0300);
    pin(1'b0, 1'b0);
    conv(HOT, 1);
    pin(1'b0, 1'b0);
    wr(TAS_PTR_CONF, 16'h0000);
    tas_host_model_inst.start();
    tas_host_model_inst.byte_io({TAS_ADDR_BASE, ~addr_sel_in, 1'b0}, 1'b1, q8, a);
    check({15'h0, a}, 16'h1);
    tas_host_model_inst.stop();
    // host stalls with scl low while the device drives a zero bit
    conv(MID, 1);
    tas_host_model_inst.start();
    xb({TAS_ADDR_BASE, addr_sel_in, 1'b1});
    repeat (8) @(posedge clk_in);
    check({15'h0, sda_oe_out}, 16'h1);
    repeat (TMO) @(posedge clk_in);
    check({15'h0, sda_oe_out}, 16'h0);
    tas_host_model_inst.stop();
    final_report();
  end
endmodule
`default_nettype wire
